/* gcisc_regs.vh */
// Constants for the GCI SC channel command/indicate handler
//
// What this block does
// - Three-bit code selects one of eight linefeed modes
// - Command equal to primary, latch clear: nothing
// - Differing command goes to secondary, latch set
// - Secondary repeated next frame: primary loaded, applied
// - Differs from both: secondary overwritten, latch kept
// - Equals primary while latched: latch cleared only
// - Line-control enable low: downstream commands ignored
// - Enable high: follow validated downstream commands
// - Enable high disables automatic linefeed transitions
// - Loop edge, ring-trip or alarm rise sets enabled status
// - Loop, ring trip, cadence, power alarm transitions
// - Upstream byte value held two frames minimum
// - Upstream interrupt bit is OR of unmasked status
// - Upstream hook bit mirrors loop closure flag
// - Upstream ground-key bit mirrors longitudinal flag
// - Each interrupt flag individually masked by enable
// - SC byte: A in 7..5, B 4..2, MR, MX
`ifndef GCISC_REGS_VH
`define GCISC_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GCISC_ADDR_CTRL 8'h00
`define GCISC_ADDR_MONMODE 8'h04
`define GCISC_ADDR_IRQSTAT 8'h08
`define GCISC_ADDR_IRQEN 8'h0C
`define GCISC_ADDR_LINESTAT 8'h10
`define GCISC_ADDR_SCBYTES 8'h14

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define GCISC_CTRL_LINE_EN 0
`define GCISC_CTRL_T1_EN 1
`define GCISC_CTRL_T2_EN 2
`define GCISC_CTRL_RST 3'h0
`define GCISC_IRQEN_RST 8'h00
// Per-channel field stride in mode and status registers
`define GCISC_CH_STRIDE 4
// Status bit positions within a channel field
`define GCISC_IRQ_LOOP 0
`define GCISC_IRQ_RTRIP 1
`define GCISC_IRQ_PALARM 2

// ----------------------------------------
// Linefeed mode codes
// ----------------------------------------
`define GCISC_MODE_OPEN 3'h0
`define GCISC_MODE_FWD_ACT 3'h1
`define GCISC_MODE_FWD_OHT 3'h2
`define GCISC_MODE_GS_TIP 3'h3
`define GCISC_MODE_RING 3'h4
`define GCISC_MODE_REV_ACT 3'h5
`define GCISC_MODE_REV_OHT 3'h6
`define GCISC_MODE_GS_RING 3'h7

// ----------------------------------------
// SC byte layout and frame timing
// ----------------------------------------
`define GCISC_SC_A_HI 7
`define GCISC_SC_B_HI 4
`define GCISC_SC_MR 1
`define GCISC_SC_MX 0
`define GCISC_SC_FIRST 8'h18
`define GCISC_SC_LAST 8'h1F
`define GCISC_US_HOLD 2'h2
`define GCISC_MRMX_IDLE 2'h3

`endif

/* gcisc_sync.v */
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module gcisc_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Data
  input wire [W-1:0] asyncIn,
  output reg [W-1:0] syncOut
);

  reg [W-1:0] meta_q;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

/* gcisc_ci_filter.v */
// Two-frame validation of one channel's downstream command bits
`timescale 1ns/1ps
`include "gcisc_regs.vh"
module gcisc_ci_filter (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Received command
  input wire frameStb,
  input wire [2:0] cmdIn,
  // Validated state
  output reg [2:0] primary_q,
  output reg [2:0] secondary_q,
  output reg latch_q,
  output reg accept_q
);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      primary_q <= `GCISC_MODE_OPEN;
      secondary_q <= `GCISC_MODE_OPEN;
      latch_q <= 1'b0;
      accept_q <= 1'b0;
    end else begin
      accept_q <= 1'b0;
      if (frameStb) begin
        if (!latch_q) begin
          if (cmdIn != primary_q) begin
            secondary_q <= cmdIn;
            latch_q <= 1'b1;
          end
        end else if (cmdIn == secondary_q) begin
          primary_q <= secondary_q;
          latch_q <= 1'b0;
          accept_q <= 1'b1;
        end else if (cmdIn == primary_q) begin
          latch_q <= 1'b0;
        end else begin
          secondary_q <= cmdIn;
        end
      end
    end
  end

endmodule

/* gcisc_top.v */
// GCI SC channel command/indicate handler, dual channel
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "gcisc_regs.vh"
module gcisc_top (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Register port
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  // GCI link pins
  input wire gciDcl,
  input wire gciFsc,
  input wire gciDrx,
  output reg gciDtxOut,
  output reg gciDtxOe,
  // Line detector inputs, bit 0 channel A, bit 1 channel B
  input wire [1:0] loopClosureIn,
  input wire [1:0] ringTripIn,
  input wire [1:0] groundKeyIn,
  input wire [1:0] powerAlarmIn,
  input wire [1:0] cadenceT1In,
  input wire [1:0] cadenceT2In,
  // Linefeed mode, [2:0] channel A, [5:3] channel B
  output wire [5:0] lineMode
);

  // ----------------------------------------
  // Input synchronisation and edges
  // ----------------------------------------
  wire [14:0] pinSync;
  reg [14:0] pinPrev_q;

  gcisc_sync #(
    .W(15)
  ) uSync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .asyncIn({cadenceT2In, cadenceT1In, powerAlarmIn, groundKeyIn,
      ringTripIn, loopClosureIn, gciDrx, gciFsc, gciDcl}),
    .syncOut(pinSync)
  );

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pinPrev_q <= 15'h0000;
    end else begin
      pinPrev_q <= pinSync;
    end
  end

  wire dclRise = pinSync[0] & ~pinPrev_q[0];
  wire fscS = pinSync[1];
  wire drxS = pinSync[2];
  wire [1:0] lcrS = pinSync[4:3];
  wire [1:0] rtpS = pinSync[6:5];
  wire [1:0] gkS = pinSync[8:7];
  wire [1:0] paS = pinSync[10:9];
  wire [1:0] lcrEdge = pinSync[4:3] ^ pinPrev_q[4:3];
  wire [1:0] rtpRise = pinSync[6:5] & ~pinPrev_q[6:5];
  wire [1:0] paRise = pinSync[10:9] & ~pinPrev_q[10:9];
  wire [1:0] t1Rise = pinSync[12:11] & ~pinPrev_q[12:11];
  wire [1:0] t2Rise = pinSync[14:13] & ~pinPrev_q[14:13];

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [2:0] ctrl_q;
  reg [7:0] irqEn_q;
  wire lineEn = ctrl_q[`GCISC_CTRL_LINE_EN];
  wire wrCtrl = regWr && (regAddr == `GCISC_ADDR_CTRL);
  wire wrMon = regWr && (regAddr == `GCISC_ADDR_MONMODE);
  wire wrStat = regWr && (regAddr == `GCISC_ADDR_IRQSTAT);
  wire wrEn = regWr && (regAddr == `GCISC_ADDR_IRQEN);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= `GCISC_CTRL_RST;
      irqEn_q <= `GCISC_IRQEN_RST;
    end else begin
      if (wrCtrl) begin
        ctrl_q <= regWdata[2:0];
      end
      if (wrEn) begin
        irqEn_q <= regWdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Frame timing and downstream SC byte
  // ----------------------------------------
  reg [7:0] bitCnt_q;
  reg [7:0] dsShift_q;
  reg [7:0] dsByte_q;
  reg frameStb_q;
  reg [7:0] usByte_q;
  wire [7:0] bitIdx = fscS ? 8'h00 : bitCnt_q + 8'h01;
  wire inSc = (bitIdx >= `GCISC_SC_FIRST) && (bitIdx <= `GCISC_SC_LAST);
  wire [7:0] scPos8 = bitIdx - `GCISC_SC_FIRST;
  wire [2:0] usSel = 3'h7 - scPos8[2:0];

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      bitCnt_q <= 8'h00;
      dsShift_q <= 8'h00;
      dsByte_q <= 8'h00;
      frameStb_q <= 1'b0;
      gciDtxOut <= 1'b1;
      gciDtxOe <= 1'b0;
    end else begin
      frameStb_q <= 1'b0;
      if (dclRise) begin
        bitCnt_q <= bitIdx;
        if (inSc) begin
          dsShift_q <= {dsShift_q[6:0], drxS};
          gciDtxOut <= usByte_q[usSel];
          gciDtxOe <= 1'b1;
        end else begin
          gciDtxOut <= 1'b1;
          gciDtxOe <= 1'b0;
        end
        if (bitIdx == `GCISC_SC_LAST) begin
          dsByte_q <= {dsShift_q[6:0], drxS};
          frameStb_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Per-channel validation, modes and status
  // ----------------------------------------
  wire [5:0] primaryAll;
  wire [1:0] latchAll;
  wire [7:0] irqStat;
  wire [1:0] irqAny;

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : gCh
      wire [2:0] cmd;
      wire [2:0] primary;
      wire latch;
      wire accept;
      reg [2:0] mode_q;
      reg [2:0] stat_q;
      reg [2:0] autoMode;
      reg autoHit;
      wire [2:0] monVal;
      wire [2:0] clr;
      wire [2:0] set;
      wire [2:0] en;

      assign cmd = (c == 0) ? dsByte_q[7:5] : dsByte_q[4:2];
      assign monVal = regWdata[c*`GCISC_CH_STRIDE +: 3];
      assign clr = wrStat ? regWdata[c*`GCISC_CH_STRIDE +: 3] : 3'h0;
      assign en = irqEn_q[c*`GCISC_CH_STRIDE +: 3];

      gcisc_ci_filter uFilt (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .frameStb(frameStb_q & lineEn),
        .cmdIn(cmd),
        .primary_q(primary),
        .secondary_q(),
        .latch_q(latch),
        .accept_q(accept)
      );

      // Automatic transitions, alarm first
      always @* begin
        autoMode = mode_q;
        autoHit = 1'b0;
        if (paRise[c]) begin
          autoMode = `GCISC_MODE_OPEN;
          autoHit = 1'b1;
        end else if (rtpRise[c] && mode_q == `GCISC_MODE_RING) begin
          autoMode = `GCISC_MODE_FWD_ACT;
          autoHit = 1'b1;
        end else if (lcrEdge[c] && lcrS[c] &&
            mode_q == `GCISC_MODE_FWD_OHT) begin
          autoMode = `GCISC_MODE_FWD_ACT;
          autoHit = 1'b1;
        end else if (lcrEdge[c] && lcrS[c] &&
            mode_q == `GCISC_MODE_REV_OHT) begin
          autoMode = `GCISC_MODE_REV_ACT;
          autoHit = 1'b1;
        end else if (lcrEdge[c] && !lcrS[c] &&
            mode_q == `GCISC_MODE_FWD_ACT) begin
          autoMode = `GCISC_MODE_FWD_OHT;
          autoHit = 1'b1;
        end else if (lcrEdge[c] && !lcrS[c] &&
            mode_q == `GCISC_MODE_REV_ACT) begin
          autoMode = `GCISC_MODE_REV_OHT;
          autoHit = 1'b1;
        end else if (t1Rise[c] && ctrl_q[`GCISC_CTRL_T1_EN] &&
            mode_q == `GCISC_MODE_RING) begin
          autoMode = `GCISC_MODE_FWD_OHT;
          autoHit = 1'b1;
        end else if (t2Rise[c] && ctrl_q[`GCISC_CTRL_T2_EN] &&
            mode_q == `GCISC_MODE_FWD_OHT) begin
          autoMode = `GCISC_MODE_RING;
          autoHit = 1'b1;
        end
      end

      always @(posedge clk_sys) begin
        if (sys_rst) begin
          mode_q <= `GCISC_MODE_OPEN;
        end else if (lineEn) begin
          if (accept) begin
            mode_q <= primary;
          end
        end else if (autoHit) begin
          mode_q <= autoMode;
        end else if (wrMon) begin
          mode_q <= monVal;
        end
      end

      // Status set only while enabled; set wins over clear
      assign set = {paRise[c], rtpRise[c], lcrEdge[c]} & en;

      always @(posedge clk_sys) begin
        if (sys_rst) begin
          stat_q <= 3'h0;
        end else begin
          stat_q <= (stat_q & ~clr) | set;
        end
      end

      assign primaryAll[c*3 +: 3] = primary;
      assign latchAll[c] = latch;
      assign lineMode[c*3 +: 3] = mode_q;
      assign irqStat[c*`GCISC_CH_STRIDE +: `GCISC_CH_STRIDE] = {1'b0, stat_q};
      assign irqAny[c] = |(stat_q & en);
    end
  endgenerate

  // ----------------------------------------
  // Upstream SC byte with two-frame hold
  // ----------------------------------------
  reg [1:0] usAge_q;
  wire [7:0] usCand = {irqAny[0], lcrS[0], gkS[0],
    irqAny[1], lcrS[1], gkS[1], `GCISC_MRMX_IDLE};
  wire [1:0] usAgeNext = (usAge_q == `GCISC_US_HOLD) ?
    usAge_q : usAge_q + 2'h1;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      usByte_q <= {6'h00, `GCISC_MRMX_IDLE};
      usAge_q <= `GCISC_US_HOLD;
    end else if (frameStb_q) begin
      if (usAgeNext == `GCISC_US_HOLD && usCand != usByte_q) begin
        usByte_q <= usCand;
        usAge_q <= 2'h0;
      end else begin
        usAge_q <= usAgeNext;
      end
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  reg [31:0] rdMux;

  always @* begin
    rdMux = 32'h0000_0000;
    case (regAddr)
      `GCISC_ADDR_CTRL: rdMux = {29'h0000_0000, ctrl_q};
      `GCISC_ADDR_MONMODE: rdMux = {25'h000_0000, lineMode[5:3],
        1'b0, lineMode[2:0]};
      `GCISC_ADDR_IRQSTAT: rdMux = {24'h00_0000, irqStat};
      `GCISC_ADDR_IRQEN: rdMux = {24'h00_0000, irqEn_q};
      `GCISC_ADDR_LINESTAT: rdMux = {18'h0_0000, gkS, lcrS, latchAll,
        1'b0, primaryAll[5:3], 1'b0, primaryAll[2:0]};
      `GCISC_ADDR_SCBYTES: rdMux = {16'h0000, usByte_q, dsByte_q};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule

/* gcisc_top_properties.sv */
// Port checker for the SC channel command/indicate handler
`timescale 1ns/1ps
module gcisc_checker (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Observed ports
  input wire regRd,
  input wire [31:0] regRdata,
  input wire gciFsc,
  input wire gciDtxOut,
  input wire gciDtxOe,
  input wire [5:0] lineMode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  reg [7:0] oeCnt_q;
  always @(posedge clk_sys) begin
    if (sys_rst || !gciDtxOe) oeCnt_q <= 8'h00;
    else oeCnt_q <= oeCnt_q + 8'h01;
  end
  sequence s_slot; gciDtxOe[*8]; endsequence
  sequence s_gap; (!gciDtxOe && gciDtxOut)[*8]; endsequence
  property p_rd_idle; !regRd |=> regRdata == 32'h0000_0000; endproperty
  property p_idle_hi; !gciDtxOe |-> gciDtxOut; endproperty
  property p_slot_open; $rose(gciDtxOe) |-> s_slot; endproperty
  property p_slot_gap; $fell(gciDtxOe) |-> s_gap; endproperty
  property p_slot_max; oeCnt_q <= 8'h42; endproperty
  property p_slot_min; $fell(gciDtxOe) |-> oeCnt_q >= 8'h3E; endproperty
  property p_fsc_off; $rose(gciDtxOe) |-> !gciFsc; endproperty
  property p_rst; $fell(sys_rst) |-> lineMode == 6'h00 && !gciDtxOe;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero when idle");
  a_idle_hi: assert property (p_idle_hi)
    else $error("upstream line not high outside slot");
  a_slot_open: assert property (p_slot_open)
    else $error("slot drive too short");
  a_slot_gap: assert property (p_slot_gap)
    else $error("slot drive resumed too soon");
  a_slot_max: assert property (p_slot_max)
    else $error("slot longer than eight bits");
  a_slot_min: assert property (p_slot_min)
    else $error("slot shorter than eight bits");
  a_fsc_off: assert property (p_fsc_off)
    else $error("slot opened at frame start");
  a_rst: assert property (p_rst)
    else $error("state after reset wrong");
endmodule
bind gcisc_top gcisc_checker gcisc_checker_inst (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .regRd(regRd), .regRdata(regRdata), .gciFsc(gciFsc),
  .gciDtxOut(gciDtxOut), .gciDtxOe(gciDtxOe), .lineMode(lineMode));

/* gcisc_host_model.sv */
// Bus host model: makes frames, sends and collects SC bytes
`timescale 1ns/1ps
module gcisc_host_model (
  // Bus pins
  output reg gciDcl,
  output reg gciFsc,
  output reg gciDrx,
  input wire gciDtx,
  // Bench side
  input wire [7:0] dsByte,
  output reg [7:0] usByte,
  output reg [15:0] frameCnt
);
  reg [7:0] cur;
  reg [7:0] sh;
  integer i;
  initial begin
    gciDcl = 1'b0;
    gciFsc = 1'b0;
    gciDrx = 1'b1;
    usByte = 8'hFF;
    frameCnt = 16'h0000;
    sh = 8'hFF;
    cur = 8'h03;
    #3;
    forever begin
      for (i = 0; i < 32; i = i + 1) begin
        gciDcl = 1'b0;
        if (i == 24) cur = dsByte;
        gciFsc = (i == 0);
        gciDrx = (i >= 24) ? cur[31 - i] : 1'b1;
        #40;
        gciDcl = 1'b1;
        if (i >= 25 || i == 0) sh = {sh[6:0], gciDtx};
        if (i == 0) begin
          usByte = sh;
          frameCnt = frameCnt + 16'h0001;
        end
        #40;
      end
    end
  end
endmodule

/* gcisc_top_test.sv */
// Testbench for the SC channel command/indicate handler
`timescale 1ns/1ps
`include "gcisc_regs.vh"
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin \
  error_cnt = error_cnt + 1; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module gcisc_top_test;
  reg clk_sys;
  reg sys_rst;
  reg [7:0] regAddr;
  reg [31:0] regWdata;
  reg regWr, regRd;
  wire [31:0] regRdata;
  wire gciDcl, gciFsc, gciDrx, gciDtxOut, gciDtxOe;
  reg [1:0] loopIn, ringIn, gkIn, palIn, t1In, t2In;
  wire [5:0] lineMode;
  reg [7:0] dsByte, lastUs;
  wire [7:0] usByte;
  wire [15:0] frameCnt;
  wire dtxWire = gciDtxOe ? gciDtxOut : 1'b1;
  integer error_cnt, checked, cyc, c, runLen;
  gcisc_top gcisc_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .gciDcl(gciDcl), .gciFsc(gciFsc), .gciDrx(gciDrx),
    .gciDtxOut(gciDtxOut), .gciDtxOe(gciDtxOe), .loopClosureIn(loopIn),
    .ringTripIn(ringIn), .groundKeyIn(gkIn), .powerAlarmIn(palIn),
    .cadenceT1In(t1In), .cadenceT2In(t2In), .lineMode(lineMode));
  gcisc_host_model gcisc_host_model_inst (.gciDcl(gciDcl), .gciFsc(gciFsc),
    .gciDrx(gciDrx), .gciDtx(dtxWire), .dsByte(dsByte), .usByte(usByte),
    .frameCnt(frameCnt));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task summarize;
    begin
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end
  // Upstream byte must stand two frames
  always @(frameCnt) begin
    if (usByte !== lastUs && cyc > 3000) `CHK(runLen > 1, 1'b1)
    runLen = (usByte !== lastUs) ? 1 : runLen + 1;
    lastUs = usByte;
  end
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      `CHK(regRdata, e)
    end
  endtask
  task frames(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) @(frameCnt);
    end
  endtask
  task send(input [2:0] a, input [2:0] b, input integer n);
    begin
      dsByte = {a, b, 2'b11};
      frames(n);
    end
  endtask
  task md(input [5:0] e);
    begin
      repeat (10) @(posedge clk_sys);
      `CHK(lineMode, e)
    end
  endtask
  initial begin
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    runLen = 2;
    sys_rst = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWr = 1'b0;
    regRd = 1'b0;
    {loopIn, ringIn, gkIn, palIn, t1In, t2In} = 12'h000;
    dsByte = 8'h03;
    lastUs = 8'h03;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // ----------------------------------------
    // Reset state, ignored commands, all codes
    // ----------------------------------------
    rdc(`GCISC_ADDR_LINESTAT, 32'h0000_0000);
    rdc(`GCISC_ADDR_CTRL, 32'h0000_0000);
    rdc(`GCISC_ADDR_IRQEN, 32'h0000_0000);
    rdc(8'h20, 32'h0000_0000);
    frames(1);
    send(3'h1, 3'h5, 3);
    rdc(`GCISC_ADDR_LINESTAT, 32'h0000_0000);
    wr(`GCISC_ADDR_CTRL, 32'h0000_0001);
    frames(1);
    for (c = 0; c < 8; c = c + 1) begin
      send(c[2:0], ~c[2:0], 2);
      md({~c[2:0], c[2:0]});
    end
    send(3'h2, 3'h0, 1);
    send(3'h3, 3'h0, 1);
    rdc(`GCISC_ADDR_LINESTAT, 32'h0000_0107);
    send(3'h7, 3'h0, 1);
    rdc(`GCISC_ADDR_LINESTAT, 32'h0000_0007);
    // ----------------------------------------
    // Upstream status and automatic moves
    // ----------------------------------------
    loopIn <= 2'b01;
    gkIn <= 2'b10;
    frames(5);
    md(6'h07);
    `CHK(usByte, 8'h47)
    rdc(`GCISC_ADDR_LINESTAT, 32'h0000_2407);
    wr(`GCISC_ADDR_CTRL, 32'h0000_0000);
    wr(`GCISC_ADDR_IRQEN, 32'h0000_0001);
    loopIn <= 2'b00;
    frames(5);
    rdc(`GCISC_ADDR_IRQSTAT, 32'h0000_0001);
    `CHK(usByte, 8'h87)
    wr(`GCISC_ADDR_IRQEN, 32'h0000_0000);
    frames(5);
    `CHK(usByte, 8'h07)
    wr(`GCISC_ADDR_IRQSTAT, 32'h0000_0077);
    wr(`GCISC_ADDR_MONMODE, 32'h0000_0004);
    wr(`GCISC_ADDR_IRQEN, 32'h0000_0002);
    ringIn <= 2'b01;
    md(6'h01);
    rdc(`GCISC_ADDR_IRQSTAT, 32'h0000_0002);
    wr(`GCISC_ADDR_IRQSTAT, 32'h0000_0077);
    wr(`GCISC_ADDR_CTRL, 32'h0000_0006);
    wr(`GCISC_ADDR_MONMODE, 32'h0000_0004);
    t1In <= 2'b01;
    md(6'h02);
    t2In <= 2'b01;
    md(6'h04);
    wr(`GCISC_ADDR_MONMODE, 32'h0000_0054);
    wr(`GCISC_ADDR_IRQEN, 32'h0000_0040);
    palIn <= 2'b10;
    md(6'h04);
    rdc(`GCISC_ADDR_IRQSTAT, 32'h0000_0040);
    frames(5);
    `CHK(usByte, 8'h17)
    // Alarm recovery by downstream commands
    wr(`GCISC_ADDR_CTRL, 32'h0000_0001);
    palIn <= 2'b00;
    frames(1);
    send(3'h4, 3'h0, 2);
    send(3'h4, 3'h5, 2);
    md(6'h2C);
    summarize;
  end
endmodule
